// *** art3_defs.vh ***
// Register map, field positions and timing constants of the auto-reload timer
`ifndef ART3_DEFS_VH
`define ART3_DEFS_VH
`define ART3_OFF_CTRL 4'h0
`define ART3_OFF_CKSEL 4'h4
`define ART3_OFF_CNT 4'h8
`define ART3_OFF_RELOAD 4'hC
`define ART3_OFF_IRQEN 5'h10
`define ART3_OFF_STATUS 5'h14
`define ART3_OFF_MASK 5'h18
`define ART3_CTRL_HOVF 7
`define ART3_CTRL_LOVF 6
`define ART3_CTRL_LOIEN 5
`define ART3_CTRL_SPLIT 3
`define ART3_CTRL_RUN 2
`define ART3_CTRL_XCLK_HI 1
`define ART3_CTRL_XCLK_LO 0
`define ART3_CK_HIGH 1
`define ART3_CK_LOW 0
`define ART3_XCLK_DIV12 2'h0
`define ART3_XCLK_RTC 2'h1
`define ART3_XCLK_RSVD 2'h2
`define ART3_XCLK_EXT8 2'h3
`define ART3_SYS_DIV 4'hB
`define ART3_EXT_DIV 3'h3
`define ART3_ST_HOVF 0
`define ART3_ST_LOVF 1
`endif

// *** art3_sync.v ***
// Two-stage synchroniser with rising edge pulse output
`timescale 1ns/10ps
`default_nettype none
module art3_sync (
  input wire aclk,
  input wire aresetn,
  input wire async_in,
  output reg rise_pulse
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_pulse <= sync_q & ~last_q;
    end
  end
endmodule // art3_sync
`default_nettype wire

// *** art3_timer.v ***
// Auto-reload timer, 16-bit or split 8-bit, with AXI4-Lite register slave
// Contract
// (R01) Split bit clear: one 16-bit counter; set: two separate 8-bit counters.
// (R02) Count sources: core clock, core clock/12, external oscillator/8, RTC oscillator.
// (R03) External/8 and RTC sources are synchronised to the core clock.
// (R04) 16-bit wrap FFFF->0000 loads reload pair and sets high overflow flag.
// (R05) 16-bit mode: interrupt on each full overflow when timer interrupt enabled.
// (R06) 16-bit mode: low byte wrap also interrupts when low enable set.
// (R07) Split mode: each half reloads from its own reload byte.
// (R08) Split mode: run control starts and stops only the high half.
// (R09) Split mode: low half counts always.
// (R10) Per-half select: 1 core clock, else external field picks source.
// (R11) Split mode: each half wrap sets its own overflow flag.
// (R12) Split: high overflow interrupts; with low enable either half interrupts.
// (R13) Overflow flags cleared only by software writing zero.
// (R14) Software reads both flags to find the interrupt source.
// (R15) 16-bit mode counts each enabled tick only while run control set.
// (R16) Reserved external encoding gives no ticks.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "art3_defs.vh"
module art3_timer (
  input wire aclk,
  input wire aresetn,
  input wire ext_osc,
  input wire rtc_osc,
  input wire [4:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq
);
  // Control and state
  reg [7:0] ctrl_q;
  reg [1:0] cksel_q;
  reg irq_en_q;
  reg [7:0] cnt_lo_q;
  reg [7:0] cnt_hi_q;
  reg [7:0] rld_lo_q;
  reg [7:0] rld_hi_q;
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg [3:0] div12_q;
  reg [2:0] div8_q;
  reg ext_div_q;
  reg tick12_q;
  reg [4:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  wire ext_tick;
  wire rtc_tick;
  // Per-half source selection
  function sel_tick;
    input core_sel;
    input [1:0] xclk;
    input t12;
    input trtc;
    input text;
    begin
      if (core_sel) begin
        sel_tick = 1'b1; // (R10)
      end else if (xclk == `ART3_XCLK_DIV12) begin
        sel_tick = t12;
      end else if (xclk == `ART3_XCLK_RTC) begin
        sel_tick = trtc;
      end else if (xclk == `ART3_XCLK_EXT8) begin
        sel_tick = text;
      end else begin
        sel_tick = 1'b0; // (R16)
      end
    end
  endfunction
  // Slow sources into core clock domain
  art3_sync u_ext_sync ( // (R03)
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(ext_div_q),
    .rise_pulse(ext_tick)
  );
  art3_sync u_rtc_sync ( // (R03)
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(rtc_osc),
    .rise_pulse(rtc_tick)
  );
  // External oscillator divider runs on the oscillator itself
  always @(posedge ext_osc) begin
    if (div8_q == `ART3_EXT_DIV) begin
      div8_q <= 3'h0;
      ext_div_q <= ~ext_div_q; // Toggle every 4 edges: one rise per 8 oscillator cycles
    end else begin
      div8_q <= div8_q + 3'h1;
    end
  end
  initial begin
    div8_q = 3'h0;
    ext_div_q = 1'b0;
  end
  // Core clock divided by 12
  always @(posedge aclk) begin
    if (!aresetn) begin
      div12_q <= 4'h0;
      tick12_q <= 1'b0;
    end else if (div12_q == `ART3_SYS_DIV) begin
      div12_q <= 4'h0;
      tick12_q <= 1'b1; // (R02)
    end else begin
      div12_q <= div12_q + 4'h1;
      tick12_q <= 1'b0;
    end
  end
  wire [1:0] xclk = ctrl_q[`ART3_CTRL_XCLK_HI:`ART3_CTRL_XCLK_LO];
  wire split = ctrl_q[`ART3_CTRL_SPLIT];
  wire run = ctrl_q[`ART3_CTRL_RUN];
  wire lo_tick = sel_tick(cksel_q[`ART3_CK_LOW], xclk, tick12_q, rtc_tick, ext_tick);
  wire hi_tick = sel_tick(cksel_q[`ART3_CK_HIGH], xclk, tick12_q, rtc_tick, ext_tick);
  // Counting events
  wire lo_adv = split ? lo_tick : (lo_tick & run); // (R09) (R15)
  wire hi_adv_s = split & hi_tick & run; // (R08)
  wire lo_wrap = lo_adv & (cnt_lo_q == 8'hFF);
  wire hi_wrap16 = ~split & lo_wrap & (cnt_hi_q == 8'hFF);
  wire hi_wrap8 = hi_adv_s & (cnt_hi_q == 8'hFF);
  wire hi_ovf = hi_wrap16 | hi_wrap8;
  wire lo_ovf = split ? lo_wrap : (lo_wrap & ~hi_wrap16);
  wire lo_int = lo_ovf & ctrl_q[`ART3_CTRL_LOIEN]; // (R06) (R12)
  // Register bus handshake
  wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] cnt_word = {16'h0000, cnt_hi_q, cnt_lo_q};
  wire wr_ctrl = do_write & (waddr_q == {1'b0, `ART3_OFF_CTRL}) & wstrb_q[0];
  wire wr_cnt = do_write & (waddr_q == {1'b0, `ART3_OFF_CNT});
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        waddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (waddr_q[1:0] != 2'h0 || waddr_q > `ART3_OFF_MASK) begin
          s_axi_bresp <= 2'h2;
        end else begin
          s_axi_bresp <= 2'h0;
        end
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Register writes and timer state
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 8'h00;
      cksel_q <= 2'h0;
      irq_en_q <= 1'b0;
      rld_lo_q <= 8'h00;
      rld_hi_q <= 8'h00;
      mask_q <= 2'h0;
      status_q <= 2'h0;
      cnt_lo_q <= 8'h00;
      cnt_hi_q <= 8'h00;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[5:0] <= wdata_q[5:0];
        // Flags only cleared by a zero write; a set from software is allowed
        ctrl_q[`ART3_CTRL_HOVF] <= wdata_q[`ART3_CTRL_HOVF] | hi_ovf; // (R13)
        ctrl_q[`ART3_CTRL_LOVF] <= wdata_q[`ART3_CTRL_LOVF] | lo_ovf; // (R13)
      end else begin
        if (hi_ovf) begin
          ctrl_q[`ART3_CTRL_HOVF] <= 1'b1; // (R04) (R11)
        end
        if (lo_ovf) begin
          ctrl_q[`ART3_CTRL_LOVF] <= 1'b1; // (R11)
        end
      end
      if (do_write & (waddr_q == {1'b0, `ART3_OFF_CKSEL}) & wstrb_q[0]) begin
        cksel_q <= wdata_q[1:0];
      end
      if (do_write & (waddr_q == {1'b0, `ART3_OFF_RELOAD})) begin
        if (wstrb_q[0]) begin
          rld_lo_q <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          rld_hi_q <= wdata_q[15:8];
        end
      end
      if (do_write & (waddr_q == `ART3_OFF_IRQEN) & wstrb_q[0]) begin
        irq_en_q <= wdata_q[0];
      end
      if (do_write & (waddr_q == `ART3_OFF_MASK) & wstrb_q[0]) begin
        mask_q <= wdata_q[1:0];
      end
      // Status: set wins over write-one-to-clear
      if (do_write & (waddr_q == `ART3_OFF_STATUS) & wstrb_q[0]) begin
        status_q <= (status_q & ~wdata_q[1:0]) | {lo_int, hi_ovf};
      end else begin
        status_q <= status_q | {lo_int, hi_ovf};
      end
      // Counter low byte
      if (wr_cnt & wstrb_q[0]) begin
        cnt_lo_q <= wdata_q[7:0];
      end else if (lo_wrap & (split | hi_wrap16)) begin
        cnt_lo_q <= rld_lo_q; // (R04) (R07)
      end else if (lo_adv) begin
        cnt_lo_q <= cnt_lo_q + 8'h01;
      end
      // Counter high byte
      if (wr_cnt & wstrb_q[1]) begin
        cnt_hi_q <= wdata_q[15:8];
      end else if (hi_wrap16 | hi_wrap8) begin
        cnt_hi_q <= rld_hi_q; // (R04) (R07)
      end else if (~split & lo_wrap) begin
        cnt_hi_q <= cnt_hi_q + 8'h01; // (R01)
      end else if (hi_adv_s) begin
        cnt_hi_q <= cnt_hi_q + 8'h01; // (R01)
      end
      irq <= irq_en_q & |(status_q & mask_q); // (R05) (R12)
    end
  end
  // Register reads
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr == {1'b0, `ART3_OFF_CTRL}) begin
        s_axi_rdata <= {24'h000000, ctrl_q};
      end else if (s_axi_araddr == {1'b0, `ART3_OFF_CKSEL}) begin
        s_axi_rdata <= {30'h00000000, cksel_q};
      end else if (s_axi_araddr == {1'b0, `ART3_OFF_CNT}) begin
        s_axi_rdata <= cnt_word;
      end else if (s_axi_araddr == {1'b0, `ART3_OFF_RELOAD}) begin
        s_axi_rdata <= {16'h0000, rld_hi_q, rld_lo_q};
      end else if (s_axi_araddr == `ART3_OFF_IRQEN) begin
        s_axi_rdata <= {31'h00000000, irq_en_q};
      end else if (s_axi_araddr == `ART3_OFF_STATUS) begin
        s_axi_rdata <= {30'h00000000, status_q};
      end else if (s_axi_araddr == `ART3_OFF_MASK) begin
        s_axi_rdata <= {30'h00000000, mask_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // art3_timer
`default_nettype wire

// *** art3_timer_props.sv ***
// Bus handshake checker for the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
module art3_timer_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer open");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
endmodule // art3_timer_props
bind art3_timer art3_timer_props art3_timer_props_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** art3_timer_tb.sv ***
// Self-checking bench of the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
module art3_timer_tb;
  logic aclk = 0, aresetn = 0, ext_osc = 0, rtc_osc = 0;
  logic [4:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  wire awr, wr_r, bv, arr, rv, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_fail = 0, checks_done = 0, cyc = 0;
  logic [31:0] d, rl;
  logic [1:0] rs;
  int lo [4] = '{9, 10, 0, 6};
  int hi [4] = '{12, 70, 0, 9};
  art3_timer art3_timer_inst (.aclk(aclk), .aresetn(aresetn), .ext_osc(ext_osc),
    .rtc_osc(rtc_osc), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .irq(irq));
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    ext_osc <= ~ext_osc;
    rtc_osc <= $urandom % 2;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awr && !ad) begin ad = 1; awv <= 0; end
      if (wr_r && !dd) begin dd = 1; wv <= 0; end
    end
    while (!bv) @(posedge aclk);
    rs = bresp;
    br <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1; rr <= 1;
    @(posedge aclk);
    while (!arr) @(posedge aclk);
    arv <= 0;
    while (!rv) @(posedge aclk);
    d = rdata; rs = rresp;
    rr <= 0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(23534));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(5'h00); chk(d, 32'h0, "control reset");
    rd(5'h1C); chk(rs, 2'h2, "unmapped read resp"); chk(d, 32'h0, "unmapped read data");
    wr(5'h1C, 32'h1); chk(rs, 2'h2, "unmapped write");
    wr(5'h10, 32'h1); wr(5'h18, 32'h3); wr(5'h04, 32'h3);
    rl = $urandom & 32'h7F00;
    wr(5'h0C, rl); wr(5'h08, 32'hFFF0); wr(5'h00, 32'h4);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b1, "irq on full wrap");
    rd(5'h08); chk(d >= rl && d <= rl + 60, 1, "reload on wrap");
    rd(5'h00); chk(d[7], 1'b1, "high flag");
    wr(5'h14, 32'h3); repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "irq cleared");
    rd(5'h00); chk(d[7], 1'b1, "flag sticky");
    wr(5'h00, 32'h0); rd(5'h00); chk(d, 32'h0, "flag cleared");
    wr(5'h0C, 32'h0055); wr(5'h08, 32'h12F8); wr(5'h00, 32'h24);
    repeat (30) @(posedge aclk);
    rd(5'h14); chk(d[1:0], 2'h2, "low wrap event");
    rd(5'h00); chk(d[7:6], 2'h1, "low flag only");
    rd(5'h08); chk(d[15:8] == 8'h13 && d[7:0] < 8'h40, 1, "low byte carries");
    rl = $urandom & 32'h7F7F;
    wr(5'h0C, rl); wr(5'h08, 32'h55F8); wr(5'h00, 32'h28);
    repeat (30) @(posedge aclk);
    rd(5'h08); chk(d[15:8], 8'h55, "high half stopped");
    chk(d[7:0] >= rl[7:0] && d[7:0] <= rl[7:0] + 40, 1, "low half reload");
    rd(5'h00); chk(d[7:6], 2'h1, "low half flag");
    wr(5'h14, 32'h3); wr(5'h08, 32'hF810); wr(5'h00, 32'h6C);
    repeat (40) @(posedge aclk);
    rd(5'h08); chk(d[15:8] >= rl[15:8] && d[15:8] <= rl[15:8] + 40, 1, "high reload");
    rd(5'h00); chk(d[7], 1'b1, "high half flag");
    rd(5'h14); chk(d[0], 1'b1, "high half event");
    wr(5'h04, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(5'h00, 32'h0); wr(5'h08, 32'h0); wr(5'h00, 32'h4 | c);
      repeat (120) @(posedge aclk);
      wr(5'h00, 32'h0); rd(5'h08);
      chk(d >= lo[c] && d <= hi[c], 1, "clock source rate");
    end
    finish_test();
  end
endmodule // art3_timer_tb
`default_nettype wire
